// file: design/codec_ext_regs.sv
// Purpose: Host register bank: index pointer, data port, capture base and extended bank
// Assumes: Host address, data and strobes are asynchronous pins; a strobe holds its
//          address and data stable while asserted
// Notes:   Writes are taken one clock after the synchronised strobe edge;
//          reads refresh every clock from the synchronised address;
//          the extended bank is open only in mode 3
`timescale 1ns/10ps
`include "codec_reg_params.svh"
module codec_ext_regs
   import codec_reg_pkg::*;
#(
   parameter int          NUM_PLAIN = 18,     // Extended indices 0..17 stored
   parameter logic [7:0]  VERSION_ID = 8'h5a  // Arbitrary value
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic [1:0]  host_addr,
   input  wire logic [7:0]  host_wdata,
   input  wire logic        host_wr_n,
   input  wire logic        host_rd_n,
   input  wire logic        host_cs_n,
   input  wire logic [1:0]  mode_sel,
   output logic      [7:0]  host_rdata,
   output logic             host_rdata_oe,
   output logic      [15:0] capture_base,
   output logic             adpcm_capture_freeze,
   output logic             init_flag,
   output logic             mode_change_enable,
   output logic             transfer_request_disable,
   output logic      [4:0]  line_alt_gain_left,
   output logic      [4:0]  line_alt_gain_right,
   output logic             line_output_mute_left,
   output logic             line_output_mute_right,
   output logic             line_input_mute_left,
   output logic             line_input_mute_right,
   output logic             line_bypass_mute_left,
   output logic             line_bypass_mute_right,
   output logic      [4:0]  mic_gain_left,
   output logic      [4:0]  mic_gain_right,
   output logic             mic_boost_left,
   output logic             mic_boost_right,
   output logic             mic_output_mute_left,
   output logic             mic_output_mute_right,
   output logic             mic_input_mute_left,
   output logic             mic_input_mute_right,
   output logic             synth_volume_remap,
   output logic             wavetable_remap_disable
);

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   logic       wr_level;      // Synchronised write strobe
   logic       wr_rise;       // Write strobe start
   logic       wr_take_reg;   // Write strobe start, one clock later
   logic       rd_level;      // Synchronised read strobe
   logic [1:0] addr_meta_reg; // Address first stage
   logic [1:0] addr_reg;      // Address second stage
   logic [7:0] wdata_meta_reg;// Data first stage
   logic [7:0] wdata_reg;     // Data second stage
   logic [1:0] mode_meta_reg; // Mode first stage
   logic [1:0] mode_reg;      // Mode second stage

   // Strobes are qualified by chip select before the synchroniser
   host_strobe_sync u_wr_sync (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .strobe_in    (~host_wr_n & ~host_cs_n),
      .strobe_level (wr_level),
      .strobe_rise  (wr_rise)
   );

   // The read strobe only drives the bus enable
   host_strobe_sync u_rd_sync (
      .sys_clk      (sys_clk),
      .rst_b        (rst_b),
      .strobe_in    (~host_rd_n & ~host_cs_n),
      .strobe_level (rd_level),
      .strobe_rise  ()
   );

   // Two flops on address, data and mode pins
   // Address and data are held by the host while the strobe is low
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_meta_reg  <= 2'h0;
         addr_reg       <= 2'h0;
         wdata_meta_reg <= 8'h00;
         wdata_reg      <= 8'h00;
         mode_meta_reg  <= 2'h0;
         mode_reg       <= 2'h0;
      end else begin
         addr_meta_reg  <= host_addr;
         addr_reg       <= addr_meta_reg;
         wdata_meta_reg <= host_wdata;
         wdata_reg      <= wdata_meta_reg;
         mode_meta_reg  <= mode_sel;
         mode_reg       <= mode_meta_reg;
      end
   end

   // Delay the write by one clock: address and data were then sampled
   // at least one clock after the strobe was first seen low, so slow
   // data setup on the bus cannot be caught half settled
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_take_reg <= 1'b0;              // No write pending
      end else begin
         wr_take_reg <= wr_rise;           // One pulse per strobe
      end
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // A write lands on exactly one clock per strobe; reads are
   // combinational from the synchronised address and the index
   logic       enhanced;       // Device in mode 3
   logic       wr_index;       // Write to index pointer
   logic       wr_data;        // Write to data port
   logic       wr_window;      // Data port write hits extended window
   logic       wr_ext;         // Data port write reaches an extended register
   reg_byte_t  index_reg;      // Index pointer
   reg_byte_t  window_reg;     // Extended window in address role
   reg_byte_t  cap_high_reg;   // Capture base high byte
   reg_byte_t  cap_low_reg;    // Capture base low byte
   reg_index_t ext_index;      // Selected extended index
   logic       ext_data_select;// Window acts as data register

   // Port decode uses the synchronised address only
   assign enhanced        = (mode_reg == `MODE_ENHANCED);
   assign wr_index        = wr_take_reg && (addr_reg == `OFS_INDEX_POINTER);
   assign wr_data         = wr_take_reg && (addr_reg == `OFS_INDEXED_DATA_PORT);
   assign wr_window       = wr_data && (index_reg[`IP_INDEX_MSB:0] == `IDX_EXTENDED_WINDOW);
   assign ext_data_select = window_reg[`EW_SELECT_BIT];
   assign ext_index       = {window_reg[`EW_ADDR_HI_BIT],
                             window_reg[`EW_ADDR_LO_MSB:`EW_ADDR_LO_LSB]};
   assign wr_ext          = wr_window && ext_data_select && enhanced;

   // ----------------------------------------
   // Index pointer
   // ----------------------------------------
   // Holds init, mode change, request disable and index fields
   // Any write here also drops the window's select bit
   // Reset value leaves mode change enabled after power-up
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         index_reg <= `RST_INDEX;
      end else if (wr_index) begin
         index_reg <= wdata_reg;
      end
   end

   // Index fields drive the rest of the codec directly
   assign init_flag                = index_reg[`IP_INIT_BIT];
   assign mode_change_enable       = index_reg[`IP_MCE_BIT];
   assign transfer_request_disable = index_reg[`IP_TRD_BIT];

   // ----------------------------------------
   // Extended window
   // ----------------------------------------
   // Address role is written while select is clear; index write drops select
   // While select is set in mode 3 the window byte is frozen, so data
   // meant for an extended register never lands in the address role
   // Reads in address role return this byte as stored, select bit cleared outside mode 3 and by index writes
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         window_reg <= `RST_WINDOW;
      end else if (wr_index) begin
         window_reg[`EW_SELECT_BIT] <= 1'b0;
      end else if (wr_window && !(ext_data_select && enhanced)) begin
         window_reg <= wdata_reg;
         if (!enhanced) begin
            // Outside mode 3 the select bit cannot be set
            window_reg[`EW_SELECT_BIT] <= 1'b0;
         end
      end
   end

   // The capture coder holds its accumulator and step size
   // for as long as this bit is set
   assign adpcm_capture_freeze = window_reg[`EW_FREEZE_BIT];

   // ----------------------------------------
   // Capture base count
   // ----------------------------------------
   // Plain read-back bytes of the 16-bit base
   // The counter that consumes the base lives outside this block
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cap_high_reg <= `RST_CAPTURE_BASE;
         cap_low_reg  <= `RST_CAPTURE_BASE;
      end else if (wr_data) begin
         if (index_reg[`IP_INDEX_MSB:0] == `IDX_CAPTURE_HIGH) begin
            cap_high_reg <= wdata_reg;
         end
         if (index_reg[`IP_INDEX_MSB:0] == `IDX_CAPTURE_LOW) begin
            cap_low_reg <= wdata_reg;
         end
      end
   end

   // Upper byte in the high half of the count
   assign capture_base = {cap_high_reg, cap_low_reg};

   // ----------------------------------------
   // Extended register storage
   // ----------------------------------------
   // Indices 18..24 have no storage and index 25 is a constant
   reg_byte_t ext_mem [NUM_PLAIN];   // Extended registers 0..17

   // Reserved indices drop writes; the version register is read-only
   // Only mode 3 with the select bit set reaches this store
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_PLAIN; i++) begin
            ext_mem[i] <= `RST_EXT_PLAIN;
         end
         ext_mem[`XR_LINE_L] <= `RST_LINE_ALT;
         ext_mem[`XR_LINE_R] <= `RST_LINE_ALT;
         ext_mem[`XR_MIC_L]  <= `RST_MIC;
         ext_mem[`XR_MIC_R]  <= `RST_MIC;
      end else if (wr_ext && (ext_index <= `XIDX_LAST_PLAIN)) begin
         ext_mem[ext_index] <= wdata_reg;
      end
   end

   // ----------------------------------------
   // Mixer control fields
   // ----------------------------------------
   // Plain wires from the stored bytes, so a write reaches the mixer
   // on the same clock that it lands

   // Line alternate: gain, bypass, input and output mutes
   assign line_alt_gain_left      = ext_mem[`XR_LINE_L][`XF_GAIN_MSB:0];
   assign line_alt_gain_right     = ext_mem[`XR_LINE_R][`XF_GAIN_MSB:0];
   assign line_output_mute_left   = ext_mem[`XR_LINE_L][`XF_LINE_OUT_BIT];
   assign line_output_mute_right  = ext_mem[`XR_LINE_R][`XF_LINE_OUT_BIT];
   assign line_input_mute_left    = ext_mem[`XR_LINE_L][`XF_LINE_IN_BIT];
   assign line_input_mute_right   = ext_mem[`XR_LINE_R][`XF_LINE_IN_BIT];
   assign line_bypass_mute_left   = ext_mem[`XR_LINE_L][`XF_LINE_BYP_BIT];
   assign line_bypass_mute_right  = ext_mem[`XR_LINE_R][`XF_LINE_BYP_BIT];

   // Microphone: gain, boost, output and input mutes
   assign mic_gain_left           = ext_mem[`XR_MIC_L][`XF_GAIN_MSB:0];
   assign mic_gain_right          = ext_mem[`XR_MIC_R][`XF_GAIN_MSB:0];
   assign mic_boost_left          = ext_mem[`XR_MIC_L][`XF_MIC_BOOST_BIT];
   assign mic_boost_right         = ext_mem[`XR_MIC_R][`XF_MIC_BOOST_BIT];
   assign mic_output_mute_left    = ext_mem[`XR_MIC_L][`XF_MIC_OUT_BIT];
   assign mic_output_mute_right   = ext_mem[`XR_MIC_R][`XF_MIC_OUT_BIT];
   assign mic_input_mute_left     = ext_mem[`XR_MIC_L][`XF_MIC_IN_BIT];
   assign mic_input_mute_right    = ext_mem[`XR_MIC_R][`XF_MIC_IN_BIT];

   // Remap bits that hand the line input to the alternate registers
   assign synth_volume_remap      = ext_mem[`XR_MIXER][`XF_SYNTH_REMAP];
   assign wavetable_remap_disable = ext_mem[`XR_MIXER][`XF_WT_REMAP_DIS];

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   reg_byte_t rd_next;   // Byte for the current read address
   reg_byte_t ext_rd;    // Byte of the selected extended register

   // ----------------------------------------
   // Extended read
   // ----------------------------------------
   // Extended read: stored, version, or zero for reserved
   // Software must not rely on the zero from a reserved index
   always_comb begin
      if (ext_index <= `XIDX_LAST_PLAIN) begin
         ext_rd = ext_mem[ext_index];
      end else if (ext_index == `XIDX_VERSION) begin
         ext_rd = VERSION_ID;
      end else begin
         ext_rd = 8'h00;
      end
   end

   // ----------------------------------------
   // Direct port read mux
   // ----------------------------------------
   // Direct port and indirect read mux
   always_comb begin
      rd_next = 8'h00;
      unique case (addr_reg)
         `OFS_INDEX_POINTER: begin
            rd_next = index_reg;
         end
         `OFS_INDEXED_DATA_PORT: begin
            unique case (index_reg[`IP_INDEX_MSB:0])
               `IDX_EXTENDED_WINDOW: begin
                  rd_next = (ext_data_select && enhanced) ? ext_rd : window_reg;
               end
               `IDX_CAPTURE_HIGH: begin
                  rd_next = cap_high_reg;
               end
               `IDX_CAPTURE_LOW: begin
                  rd_next = cap_low_reg;
               end
               default: begin
                  rd_next = 8'h00;
               end
            endcase
         end
         `OFS_DIRECT_2, `OFS_DIRECT_3: begin
            rd_next = 8'h00;
         end
      endcase
   end

   // ----------------------------------------
   // Read data register
   // ----------------------------------------
   // Registered read data and drive enable while the read strobe is held
   // Data refresh every clock; the bus only looks while the enable is high
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         host_rdata    <= 8'h00;
         host_rdata_oe <= 1'b0;
      end else begin
         host_rdata    <= rd_next;
         host_rdata_oe <= rd_level;
      end
   end

endmodule // codec_ext_regs

// file: design/codec_reg_params.svh
// Purpose: Offsets, field positions, reset values and indices for the codec register bank
// Assumes: Byte-wide host I/O port with a two-bit address
// Notes:   Definitions only
`ifndef CODEC_REG_PARAMS_SVH
`define CODEC_REG_PARAMS_SVH

// ----------------------------------------
// Direct port offsets
// ----------------------------------------
`define OFS_INDEX_POINTER     2'h0
`define OFS_INDEXED_DATA_PORT 2'h1
`define OFS_DIRECT_2          2'h2
`define OFS_DIRECT_3          2'h3

// ----------------------------------------
// Index pointer fields
// ----------------------------------------
`define IP_INIT_BIT   7
`define IP_MCE_BIT    6
`define IP_TRD_BIT    5
`define IP_INDEX_MSB  4

// ----------------------------------------
// Indirect indices
// ----------------------------------------
`define IDX_EXTENDED_WINDOW 5'h17
`define IDX_CAPTURE_HIGH    5'h1e
`define IDX_CAPTURE_LOW     5'h1f

// ----------------------------------------
// Extended window fields
// ----------------------------------------
`define EW_ADDR_LO_MSB   7
`define EW_ADDR_LO_LSB   4
`define EW_SELECT_BIT    3
`define EW_ADDR_HI_BIT   2
`define EW_FREEZE_BIT    0

// ----------------------------------------
// Extended indices
// ----------------------------------------
`define XIDX_LAST_PLAIN  5'h11
`define XIDX_VERSION     5'h19

// ----------------------------------------
// Extended register fields
// ----------------------------------------
`define XR_LINE_L        0
`define XR_LINE_R        1
`define XR_MIC_L         2
`define XR_MIC_R         3
`define XR_MIXER         4
`define XF_GAIN_MSB      4
`define XF_LINE_BYP_BIT  5
`define XF_LINE_IN_BIT   6
`define XF_LINE_OUT_BIT  7
`define XF_MIC_BOOST_BIT 5
`define XF_MIC_OUT_BIT   6
`define XF_MIC_IN_BIT    7
`define XF_SYNTH_REMAP   2
`define XF_WT_REMAP_DIS  3

// ----------------------------------------
// Reset values and the mode 3 code
// ----------------------------------------
`define RST_CAPTURE_BASE 8'h00
`define RST_LINE_ALT     8'he8
`define RST_MIC          8'hcf
`define RST_EXT_PLAIN    8'h00
`define RST_INDEX        8'h40
`define RST_WINDOW       8'h00
`define MODE_ENHANCED    2'h3

`endif

// file: design/codec_reg_pkg.sv
// Purpose: Types shared by the codec register bank
// Assumes: Constants live in codec_reg_params.svh
// Notes:   Types only
package codec_reg_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [4:0] reg_index_t;
   typedef enum logic [1:0] {MODE_1, MODE_2, MODE_RSVD, MODE_3} codec_mode_t;
endpackage

// file: design/host_strobe_sync.sv
// Purpose: Two-flop synchroniser and rising-edge detector for a host strobe
// Assumes: Strobe is asynchronous to sys_clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module host_strobe_sync (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic strobe_in,
   output logic      strobe_level,
   output logic      strobe_rise
);
   logic meta_reg;   // First synchroniser stage
   logic sync_reg;   // Second synchroniser stage
   logic prev_reg;   // Delayed copy for edge detection

   // Synchronise and delay the strobe
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= strobe_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign strobe_level = sync_reg;
   assign strobe_rise  = sync_reg & ~prev_reg;
endmodule // host_strobe_sync

// file: verif/codec_reg_monitor.sv
// Purpose: Port checks for the codec register bank
// Assumes: Host strobes are held low for six clocks
// Notes:   Bound from the testbench top file
`timescale 1ns/10ps
module codec_reg_monitor
   import codec_reg_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic [1:0]  host_addr,
   input wire logic [7:0]  host_wdata,
   input wire logic        host_wr_n,
   input wire logic        host_rd_n,
   input wire logic        host_cs_n,
   input wire logic [1:0]  mode_sel,
   input wire logic        host_rdata_oe,
   input wire logic [15:0] capture_base,
   input wire logic        adpcm_capture_freeze,
   input wire logic        init_flag,
   input wire logic        mode_change_enable,
   input wire logic        transfer_request_disable,
   input wire logic [4:0]  line_alt_gain_left,
   input wire logic        line_output_mute_left,
   input wire logic [4:0]  mic_gain_left,
   input wire logic [4:0]  mic_gain_right,
   input wire logic        mic_output_mute_right
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ------------------------------
   // Strobe decode and idle counts
   // ------------------------------
   wire        wr_act = !host_wr_n && !host_cs_n;          // Write strobe active
   wire        rd_act = !host_rd_n && !host_cs_n;          // Read strobe active
   wire        wr0    = wr_act && (host_addr == 2'h0);     // Index pointer write
   logic [3:0] wr_idle_reg, rd_idle_reg, mode_off_reg;     // Saturating cycle counts
   // Counts cycles since each strobe, and since enhanced mode was last seen
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         {wr_idle_reg, rd_idle_reg, mode_off_reg} <= 12'h000;
      end else begin
         wr_idle_reg  <= wr_act ? 4'h0 : wr_idle_reg + {3'h0, wr_idle_reg != 4'hf};
         rd_idle_reg  <= rd_act ? 4'h0 : rd_idle_reg + {3'h0, rd_idle_reg != 4'hf};
         mode_off_reg <= (mode_sel == 2'h3) ? 4'h0 : mode_off_reg + {3'h0, mode_off_reg != 4'hf};
      end
   end
   // ------------------------------
   // Properties
   // ------------------------------
   property p_rst_line; $rose(rst_b) |-> line_alt_gain_left == 5'h08 && line_output_mute_left; endproperty
   a_rst_line: assert property (p_rst_line) else $error("line alternate reset wrong");
   property p_rst_mic; $rose(rst_b) |-> mic_gain_right == 5'h0f && mic_output_mute_right; endproperty
   a_rst_mic: assert property (p_rst_mic) else $error("mic reset wrong");
   property p_rst_capture; $rose(rst_b) |-> capture_base == 16'h0000; endproperty
   a_rst_capture: assert property (p_rst_capture) else $error("capture reset wrong");
   property p_capture_quiet; wr_idle_reg > 4'h4 |-> $stable(capture_base); endproperty
   a_capture_quiet: assert property (p_capture_quiet) else $error("capture moved without write");
   property p_freeze_quiet; wr_idle_reg > 4'h4 |-> $stable(adpcm_capture_freeze); endproperty
   a_freeze_quiet: assert property (p_freeze_quiet) else $error("freeze moved without write");
   property p_ext_mode;
      !$stable({line_alt_gain_left, mic_gain_left, mic_gain_right}) |-> mode_off_reg < 4'h6;
   endproperty
   a_ext_mode: assert property (p_ext_mode) else $error("extended change outside mode 3");
   property p_index_fields;
      wr0 [*6] |-> {init_flag, mode_change_enable, transfer_request_disable} == host_wdata[7:5];
   endproperty
   a_index_fields: assert property (p_index_fields) else $error("index fields wrong");
   property p_oe_cause; $rose(host_rdata_oe) |-> rd_idle_reg == 4'h0; endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("enable rose without read");
   property p_oe_quiet; rd_idle_reg > 4'h5 |-> !host_rdata_oe; endproperty
   a_oe_quiet: assert property (p_oe_quiet) else $error("enable stuck after read");
   c_index_write: cover property (wr0 [*6]);
   c_read_oe: cover property ($rose(host_rdata_oe));
   c_mode_off: cover property (mode_off_reg == 4'h6);
endmodule // codec_reg_monitor

// file: verif/host_io_model.sv
// Purpose: Host software model driving the codec I/O ports
// Assumes: Strobes held six clocks low, at least four high
// Notes:   Tasks are called from the testbench
`timescale 1ns/10ps
module host_io_model
   import codec_reg_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic [7:0] host_rdata,
   output logic      [1:0] host_addr,
   output logic      [7:0] host_wdata,
   output logic            host_wr_n,
   output logic            host_rd_n,
   output logic            host_cs_n,
   output logic            rd_done,
   output logic      [7:0] rd_value
);
   // Idle bus at time zero
   initial begin
      host_addr  = 2'h0;
      host_wdata = 8'h00;
      host_wr_n  = 1'b1;
      host_rd_n  = 1'b1;
      host_cs_n  = 1'b1;
      rd_done    = 1'b0;
      rd_value   = 8'h00;
   end
   // One strobe: six clocks low, then released; read byte taken at release
   task automatic io_cycle(input logic [1:0] a, input logic [7:0] dat, input logic is_rd);
      @(posedge sys_clk);
      host_addr  <= a;
      host_wdata <= dat;
      host_cs_n  <= 1'b0;
      host_wr_n  <= is_rd;
      host_rd_n  <= !is_rd;
      repeat (6) @(posedge sys_clk);
      rd_value   <= host_rdata;
      rd_done    <= is_rd;
      host_cs_n  <= 1'b1;
      host_wr_n  <= 1'b1;
      host_rd_n  <= 1'b1;
      host_wdata <= ~dat;   // Released data shows the inverse, not the last value
      @(posedge sys_clk);
      rd_done    <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   // Point the window at an extended register in data role
   task automatic ext_open(input logic [4:0] x);
      io_cycle(2'h0, 8'h17, 1'b0);
      io_cycle(2'h1, {x[3:0], 1'b1, x[4], 2'b00}, 1'b0);
   endtask
endmodule // host_io_model

// file: verif/testbench.sv
// Purpose: Self-checking bench for the codec register bank
// Assumes: Host model performs every bus cycle
// Notes:   Reads are compared against a queue of expected bytes
`timescale 1ns/10ps
module testbench
   import codec_reg_pkg::*;
;
   localparam logic [7:0] VERSION_VAL = 8'h3c;   // Arbitrary identity value
   localparam logic [7:0] RST_TBL [4] = '{8'he8, 8'he8, 8'hcf, 8'hcf};
   logic        sys_clk, rst_b, host_wr_n, host_rd_n, host_cs_n, host_rdata_oe, rd_done;
   logic [1:0]  host_addr, mode_sel;
   logic [7:0]  host_wdata, host_rdata, rd_value, d;
   logic [15:0] capture_base;
   logic [4:0]  line_alt_gain_left, line_alt_gain_right, mic_gain_left, mic_gain_right;
   logic        adpcm_capture_freeze, init_flag, mode_change_enable, transfer_request_disable;
   logic        line_output_mute_left, line_output_mute_right, line_input_mute_left, line_input_mute_right;
   logic        line_bypass_mute_left, line_bypass_mute_right, mic_boost_left, mic_boost_right;
   logic        mic_output_mute_left, mic_output_mute_right, mic_input_mute_left, mic_input_mute_right;
   logic        synth_volume_remap, wavetable_remap_disable;
   logic [7:0]  fld [4];     // Last byte written to extended 0..3 by the field loop
   logic [7:0]  exp_q [$];   // Expected read bytes, oldest first
   int          error_cnt, check_count, seed_val;
   codec_ext_regs #(.VERSION_ID(VERSION_VAL)) i_dut (.*);
   host_io_model i_host (.*);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      check_count++;
      if (seen !== want) begin
         error_cnt++;
         $display("Error t=%0t saw %h want %h", $time, seen, want);
      end
   endtask
   // Watcher: each finished read takes the oldest expectation
   always @(posedge sys_clk) begin
      if (rd_done === 1'b1) begin
         check(rd_value, exp_q.pop_front());
      end
   end
   task automatic rd_expect(input logic [1:0] a, input logic [7:0] want);
      exp_q.push_back(want);
      i_host.io_cycle(a, 8'h00, 1'b1);
   endtask
   task automatic ind_wr(input logic [4:0] i, input logic [7:0] dat);
      i_host.io_cycle(2'h0, {3'h0, i}, 1'b0);
      i_host.io_cycle(2'h1, dat, 1'b0);
   endtask
   task automatic ind_rd(input logic [4:0] i, input logic [7:0] want);
      i_host.io_cycle(2'h0, {3'h0, i}, 1'b0);
      rd_expect(2'h1, want);
   endtask
   task automatic ext_wr(input logic [4:0] x, input logic [7:0] dat);
      i_host.ext_open(x);
      i_host.io_cycle(2'h1, dat, 1'b0);
   endtask
   task automatic ext_rd(input logic [4:0] x, input logic [7:0] want);
      i_host.ext_open(x);
      rd_expect(2'h1, want);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      print_verdict();
   end
   initial begin
      rst_b = 1'b0;
      mode_sel = 2'h3;
      error_cnt = 0;
      check_count = 0;
      seed_val = $urandom(32'h37d6);
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd_expect(2'h0, 8'h40);
      for (int x = 0; x < 4; x++) begin
         ext_rd(x[4:0], RST_TBL[x]);
      end
      ind_rd(5'h1e, 8'h00);
      ind_rd(5'h1f, 8'h00);
      $display("test reset values done");
      d = 8'($urandom);
      ind_wr(5'h1e, d);
      ind_wr(5'h1f, ~d);
      ind_rd(5'h1e, d);
      ind_rd(5'h1f, ~d);
      check(capture_base[15:8], d);
      check(capture_base[7:0], ~d);
      i_host.io_cycle(2'h0, 8'ha3, 1'b0);
      check({5'h00, init_flag, mode_change_enable, transfer_request_disable}, 8'h05);
      rd_expect(2'h0, 8'ha3);
      ind_wr(5'h05, 8'hff);
      ind_rd(5'h05, 8'h00);
      i_host.io_cycle(2'h2, 8'hff, 1'b0);
      rd_expect(2'h2, 8'h00);
      $display("test direct and indirect done");
      for (int k = 0; k < 8; k++) begin
         d = 8'($urandom);
         fld[k % 4] = d;
         ext_wr(5'(k % 4), d);
         ext_rd(5'(k % 4), d);
      end
      check({line_output_mute_left, line_input_mute_left, line_bypass_mute_left,
             line_alt_gain_left}, fld[0]);
      check({line_output_mute_right, line_input_mute_right, line_bypass_mute_right,
             line_alt_gain_right}, fld[1]);
      check({mic_input_mute_left, mic_output_mute_left, mic_boost_left, mic_gain_left}, fld[2]);
      check({mic_input_mute_right, mic_output_mute_right, mic_boost_right, mic_gain_right}, fld[3]);
      ext_wr(5'h04, 8'h08);
      check({6'h00, synth_volume_remap, wavetable_remap_disable}, 8'h01);
      for (int x = 18; x < 25; x++) begin
         ext_rd(5'(x), 8'h00);
      end
      ext_wr(5'h19, ~VERSION_VAL);
      ext_rd(5'h19, VERSION_VAL);
      $display("test extended bank done");
      ext_wr(5'h02, 8'h55);
      i_host.io_cycle(2'h0, 8'h17, 1'b0);
      rd_expect(2'h1, 8'h20);
      i_host.io_cycle(2'h1, 8'h31, 1'b0);
      check({7'h00, adpcm_capture_freeze}, 8'h01);
      rd_expect(2'h1, 8'h31);
      ext_rd(5'h03, fld[3]);
      mode_sel <= 2'h1;
      repeat (5) @(posedge sys_clk);
      ext_wr(5'h02, 8'h00);
      mode_sel <= 2'h3;
      repeat (5) @(posedge sys_clk);
      ext_rd(5'h02, 8'h55);
      $display("test window and mode done");
      print_verdict();
   end
endmodule // testbench
bind codec_ext_regs codec_reg_monitor i_mon (.*);
